// ### ceie_clock_event_irq.sv
// Event flags, interrupt enables and interrupt output of the clock controller
//
// Function
// - Calibration finish sets the calibration-complete flag
// - Enable-set bit 0 enables fast-osc interrupt
// - Enable-set bit 1 enables slow-clock interrupt
// - Enable-set bit 2 enables calibration-done interrupt
// - Enable-set bit 3 enables timer-timeout interrupt
`timescale 1ns/1ns
`default_nettype none
`include "ceie_params.svh"

module ceie_clock_event_irq (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire ceie_pkg::ceie_addr_t reg_addr_in,
  input wire ceie_pkg::ceie_word_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output ceie_pkg::ceie_word_t reg_rdata_out,
  input wire logic fast_osc_started_in,
  input wire logic slow_clock_started_in,
  input wire logic calibration_done_in,
  input wire logic cal_timer_expired_in,
  output logic irq_out
);
  import ceie_pkg::*;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------

  // Maps a byte address to a register select; low two bits must be zero
  function automatic ceie_sel_t decode_addr(input ceie_addr_t addr);
    ceie_sel_t sel;
    sel = CEIE_SEL_NONE;
    case (addr)
      `CEIE_OFF_FAST_STARTED: sel = CEIE_SEL_FAST;
      `CEIE_OFF_SLOW_STARTED: sel = CEIE_SEL_SLOW;
      `CEIE_OFF_CAL_DONE: sel = CEIE_SEL_DONE;
      `CEIE_OFF_CAL_TIMEOUT: sel = CEIE_SEL_TMO;
      `CEIE_OFF_IRQ_EN_SET: sel = CEIE_SEL_EN_SET;
      `CEIE_OFF_IRQ_STATUS: sel = CEIE_SEL_STATUS;
      `CEIE_OFF_IRQ_CLEAR: sel = CEIE_SEL_CLEAR;
      default: sel = CEIE_SEL_NONE;
    endcase
    return sel;
  endfunction

  // Select of the event word that holds a given flag bit
  function automatic ceie_sel_t flag_sel(input int idx);
    ceie_sel_t sel;
    sel = CEIE_SEL_NONE;
    case (idx)
      `CEIE_BIT_FAST: sel = CEIE_SEL_FAST;
      `CEIE_BIT_SLOW: sel = CEIE_SEL_SLOW;
      `CEIE_BIT_DONE: sel = CEIE_SEL_DONE;
      `CEIE_BIT_TMO: sel = CEIE_SEL_TMO;
      default: sel = CEIE_SEL_NONE;
    endcase
    return sel;
  endfunction

  ceie_sel_t wr_sel;
  ceie_sel_t rd_sel;
  ceie_evt_t evt_in;
  ceie_evt_t flag_r;
  ceie_evt_t flag_nxt;
  ceie_evt_t en_r;
  ceie_evt_t en_nxt;
  ceie_word_t rdata_r;
  ceie_word_t rdata_nxt;
  logic evt_clear_done;
  logic irq_cause;

  // Decode only while the matching strobe is high
  assign wr_sel = reg_wr_in ? decode_addr(reg_addr_in) : CEIE_SEL_NONE;
  assign rd_sel = reg_rd_in ? decode_addr(reg_addr_in) : CEIE_SEL_NONE;

  // Event pulses come from logic on this clock, so no synchroniser
  assign evt_in[`CEIE_BIT_FAST] = fast_osc_started_in;
  assign evt_in[`CEIE_BIT_SLOW] = slow_clock_started_in;
  assign evt_in[`CEIE_BIT_DONE] = calibration_done_in;
  assign evt_in[`CEIE_BIT_TMO] = cal_timer_expired_in;

  // Helpers for the assertions: a write that would clear the calibration
  // flag, and anything that may legally raise the interrupt
  assign evt_clear_done = (wr_sel == CEIE_SEL_DONE && !reg_wdata_in[0])
    || (wr_sel == CEIE_SEL_CLEAR && reg_wdata_in[`CEIE_BIT_DONE]);
  assign irq_cause = reg_wr_in || (|evt_in);

  // ----------------------------------------
  // Event flags
  // ----------------------------------------

  // Hardware set beats any software write in the same cycle, so an
  // event that lands on a clear is never lost
  always_comb begin
    flag_nxt = flag_r;
    for (int i = 0; i < `CEIE_NUM_EVT; i++) begin
      if (evt_in[i]) begin
        flag_nxt[i] = 1'b1;
      end else if (wr_sel == flag_sel(i)) begin
        flag_nxt[i] = reg_wdata_in[0];
      end else if (wr_sel == CEIE_SEL_CLEAR && reg_wdata_in[i]) begin
        flag_nxt[i] = 1'b0;
      end
    end
  end

  // Flags hold until cleared by software
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flag_r <= `CEIE_FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // ----------------------------------------
  // Interrupt enables
  // ----------------------------------------

  // Set-only register: ones enable, zeros leave the bit as it was.
  // No disable path exists here, so enables fall only at reset.
  always_comb begin
    en_nxt = en_r;
    if (wr_sel == CEIE_SEL_EN_SET) begin
      en_nxt[`CEIE_BIT_FAST] = en_r[`CEIE_BIT_FAST] | reg_wdata_in[`CEIE_BIT_FAST];
      en_nxt[`CEIE_BIT_SLOW] = en_r[`CEIE_BIT_SLOW] | reg_wdata_in[`CEIE_BIT_SLOW];
      en_nxt[`CEIE_BIT_DONE] = en_r[`CEIE_BIT_DONE] | reg_wdata_in[`CEIE_BIT_DONE];
      en_nxt[`CEIE_BIT_TMO] = en_r[`CEIE_BIT_TMO] | reg_wdata_in[`CEIE_BIT_TMO];
    end
  end

  // Enable state
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      en_r <= `CEIE_EN_RST;
    end else begin
      en_r <= en_nxt;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------

  // Unmapped and write-only words read as zero
  always_comb begin
    rdata_nxt = `CEIE_RDATA_RST;
    case (rd_sel)
      CEIE_SEL_FAST: rdata_nxt[0] = flag_r[`CEIE_BIT_FAST];
      CEIE_SEL_SLOW: rdata_nxt[0] = flag_r[`CEIE_BIT_SLOW];
      CEIE_SEL_DONE: rdata_nxt[0] = flag_r[`CEIE_BIT_DONE];
      CEIE_SEL_TMO: rdata_nxt[0] = flag_r[`CEIE_BIT_TMO];
      CEIE_SEL_EN_SET: rdata_nxt[3:0] = en_r;
      CEIE_SEL_STATUS: rdata_nxt[3:0] = flag_r;
      default: rdata_nxt = `CEIE_RDATA_RST;
    endcase
  end

  // Data stand for one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_r <= `CEIE_RDATA_RST;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------

  // Level, combinational from flops so it drops the cycle a flag clears
  assign irq_out = |(flag_r & en_r);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // Read request on a given select
  sequence seq_rd(ceie_sel_t s);
    rd_sel == s;
  endsequence

  // Write of the enable-set word carrying a one in bit b
  sequence seq_en_one(int b);
    wr_sel == CEIE_SEL_EN_SET && reg_wdata_in[b];
  endsequence

  // Calibration finish, a cycle with no clearing write, then a read of its word
  sequence seq_done_then_read;
    calibration_done_in ##1 !evt_clear_done ##1 rd_sel == CEIE_SEL_DONE;
  endsequence

  // Enable-set write with bit b, then a readback within a few cycles
  sequence seq_en_then_read(int b);
    seq_en_one(b) ##[1:4] seq_rd(CEIE_SEL_EN_SET);
  endsequence

  // A finish sets the flag on the next edge
  AST_DONE_SETS: assert property (
    calibration_done_in |=> flag_r[`CEIE_BIT_DONE]
  ) else $error("calibration flag not set after finish");

  // The flag then reads back as one
  AST_DONE_READS_ONE: assert property (
    seq_done_then_read |=> reg_rdata_out == 32'h0000_0001
  ) else $error("calibration flag did not read one");

  // A one in bit 0 enables the fast oscillator interrupt, raising irq if its flag is set
  AST_EN_FAST: assert property (
    seq_en_one(`CEIE_BIT_FAST) |=> en_r[`CEIE_BIT_FAST]
      && (irq_out || !flag_r[`CEIE_BIT_FAST])
  ) else $error("fast oscillator enable not set");

  // Readback of enables, in the cycle after the strobe, matches state as it stood at the strobe
  AST_EN_READBACK: assert property (
    seq_rd(CEIE_SEL_EN_SET) |=> reg_rdata_out == {28'h000_0000, $past(en_r)}
  ) else $error("enable readback mismatch");

  // Bit 1 enables the slow clock interrupt
  AST_EN_SLOW: assert property (
    seq_en_one(`CEIE_BIT_SLOW) |=> en_r[`CEIE_BIT_SLOW]
  ) else $error("slow clock enable not set");

  // Bit 2 enables the calibration interrupt, raising irq with its flag
  AST_EN_DONE: assert property (
    seq_en_one(`CEIE_BIT_DONE) ##0 flag_r[`CEIE_BIT_DONE] && !evt_clear_done
      |=> irq_out
  ) else $error("calibration interrupt not raised");

  // Bit 3 enables the timeout interrupt
  AST_EN_TMO: assert property (
    seq_en_one(`CEIE_BIT_TMO) |=> en_r[`CEIE_BIT_TMO]
  ) else $error("timeout enable not set");

  // Writing zeros to the enable-set word changes nothing
  AST_EN_ZERO_KEEPS: assert property (
    wr_sel == CEIE_SEL_EN_SET |=> en_r == ($past(en_r) | $past(reg_wdata_in[3:0]))
  ) else $error("enable changed other than by set");

  // A set flag stays set while no software clear is seen
  AST_FLAG_STICKY: assert property (
    flag_r[`CEIE_BIT_TMO] && wr_sel != CEIE_SEL_TMO && wr_sel != CEIE_SEL_CLEAR
      |=> flag_r[`CEIE_BIT_TMO]
  ) else $error("timeout flag dropped without clear");

  // An event in the clearing cycle still leaves the flag set
  AST_SET_BEATS_CLEAR: assert property (
    slow_clock_started_in && wr_sel == CEIE_SEL_SLOW && !reg_wdata_in[0]
      |=> flag_r[`CEIE_BIT_SLOW] [*1] ##0 (irq_out || !en_r[`CEIE_BIT_SLOW])
  ) else $error("set lost against clear");

  // Read data are zero in any cycle not following a read strobe
  AST_RDATA_ONLY_AFTER_READ: assert property (
    !reg_rd_in |=> reg_rdata_out == 32'h0000_0000
  ) else $error("read data outside read cycle");

  // Enables never drop, so only a flag-clearing write can lower the interrupt
  AST_IRQ_FALL_CAUSE: assert property (
    $fell(irq_out) |-> $past(irq_cause) && $past(reg_wr_in)
  ) else $error("interrupt fell without a write");

  // The interrupt rises only after an event or a register write
  AST_IRQ_RISE_CAUSE: assert property (
    $rose(irq_out) |-> $past(irq_cause)
  ) else $error("interrupt rose without a cause");

  // The other events set their own flags on the next edge
  AST_FAST_SETS: assert property (
    fast_osc_started_in |=> flag_r[`CEIE_BIT_FAST]
  ) else $error("fast oscillator flag not set");
  AST_SLOW_SETS: assert property (
    slow_clock_started_in |=> flag_r[`CEIE_BIT_SLOW]
  ) else $error("slow clock flag not set");
  AST_TMO_SETS: assert property (
    cal_timer_expired_in |=> flag_r[`CEIE_BIT_TMO]
  ) else $error("timeout flag not set");

  // The remaining flags also hold while no software clear is seen
  AST_FAST_STICKY: assert property (
    flag_r[`CEIE_BIT_FAST] && wr_sel != CEIE_SEL_FAST && wr_sel != CEIE_SEL_CLEAR
      |=> flag_r[`CEIE_BIT_FAST]
  ) else $error("fast oscillator flag dropped without clear");
  AST_SLOW_STICKY: assert property (
    flag_r[`CEIE_BIT_SLOW] && wr_sel != CEIE_SEL_SLOW && wr_sel != CEIE_SEL_CLEAR
      |=> flag_r[`CEIE_BIT_SLOW]
  ) else $error("slow clock flag dropped without clear");
  AST_DONE_STICKY: assert property (
    flag_r[`CEIE_BIT_DONE] && wr_sel != CEIE_SEL_DONE && wr_sel != CEIE_SEL_CLEAR
      |=> flag_r[`CEIE_BIT_DONE]
  ) else $error("calibration flag dropped without clear");

  // A zero written to the calibration word clears it unless an event lands
  AST_DONE_WORD_CLEARS: assert property (
    wr_sel == CEIE_SEL_DONE && !reg_wdata_in[0] && !calibration_done_in
      |=> !flag_r[`CEIE_BIT_DONE]
  ) else $error("calibration flag not cleared by zero write");

  // A one written to an event word sets its flag as well
  AST_TMO_WORD_SETS: assert property (
    wr_sel == CEIE_SEL_TMO && reg_wdata_in[0] |=> flag_r[`CEIE_BIT_TMO]
  ) else $error("timeout flag not set by write");

  // A one in the clear word drops the flag unless an event lands with it
  AST_CLEAR_DROPS_SLOW: assert property (
    wr_sel == CEIE_SEL_CLEAR && reg_wdata_in[`CEIE_BIT_SLOW] && !slow_clock_started_in
      |=> !flag_r[`CEIE_BIT_SLOW]
  ) else $error("slow clock flag not cleared");

  // The calibration word reads the flag as it stood at the strobe
  AST_DONE_READBACK: assert property (
    seq_rd(CEIE_SEL_DONE)
      |=> reg_rdata_out == {31'h0000_0000, $past(flag_r[`CEIE_BIT_DONE])}
  ) else $error("calibration word readback mismatch");

  // The status word shows all four flags
  AST_STATUS_READBACK: assert property (
    seq_rd(CEIE_SEL_STATUS) |=> reg_rdata_out == {28'h000_0000, $past(flag_r)}
  ) else $error("status readback mismatch");

  // The clear word is write-only and reads as zero
  AST_CLEAR_READS_ZERO: assert property (
    seq_rd(CEIE_SEL_CLEAR) |=> reg_rdata_out == 32'h0000_0000
  ) else $error("clear word read not zero");

  // No disable path: an enable once set stays set until reset
  AST_EN_NEVER_FALLS: assert property (
    (en_r & $past(en_r)) == $past(en_r)
  ) else $error("enable dropped without reset");

  // An enabled calibration interrupt reads back as one
  AST_EN_DONE_READBACK: assert property (
    seq_en_then_read(`CEIE_BIT_DONE) |=> reg_rdata_out[`CEIE_BIT_DONE]
  ) else $error("calibration enable readback not one");

  // An enabled timeout interrupt reads back as one
  AST_EN_TMO_READBACK: assert property (
    seq_en_then_read(`CEIE_BIT_TMO) |=> reg_rdata_out[`CEIE_BIT_TMO]
  ) else $error("timeout enable readback not one");

endmodule
`default_nettype wire

// ### ceie_params.svh
// Offsets, bit positions and reset values of the clock event interrupt block
`ifndef CEIE_PARAMS_SVH
`define CEIE_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CEIE_OFF_FAST_STARTED 12'h100
`define CEIE_OFF_SLOW_STARTED 12'h104
`define CEIE_OFF_CAL_DONE 12'h10C
`define CEIE_OFF_CAL_TIMEOUT 12'h110
`define CEIE_OFF_IRQ_EN_SET 12'h304
`define CEIE_OFF_IRQ_STATUS 12'h320
`define CEIE_OFF_IRQ_CLEAR 12'h324

// ----------------------------------------
// Event bit positions, shared by enable, status and clear
// ----------------------------------------
`define CEIE_BIT_FAST 0
`define CEIE_BIT_SLOW 1
`define CEIE_BIT_DONE 2
`define CEIE_BIT_TMO 3
`define CEIE_NUM_EVT 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CEIE_FLAG_RST 4'h0
`define CEIE_EN_RST 4'h0
`define CEIE_RDATA_RST 32'h0000_0000

`endif

// ### ceie_pkg.sv
// Types shared by the clock event interrupt block
`default_nettype none
package ceie_pkg;

  // ----------------------------------------
  // Bus and event types
  // ----------------------------------------
  typedef logic [11:0] ceie_addr_t;
  typedef logic [31:0] ceie_word_t;
  typedef logic [3:0] ceie_evt_t;

  // Decoded register select, one value per mapped word
  typedef enum logic [2:0] {
    CEIE_SEL_NONE = 3'h0,
    CEIE_SEL_FAST = 3'h1,
    CEIE_SEL_SLOW = 3'h3,
    CEIE_SEL_DONE = 3'h2,
    CEIE_SEL_TMO = 3'h6,
    CEIE_SEL_EN_SET = 3'h7,
    CEIE_SEL_STATUS = 3'h5,
    CEIE_SEL_CLEAR = 3'h4
  } ceie_sel_t;

endpackage
`default_nettype wire

// ### test_clock_event_irq_enable.sv
// Self-checking bench for the clock event flag and interrupt enable block
`timescale 1ns/1ns
`default_nettype none
`include "ceie_params.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end

module test_clock_event_irq_enable;
  import ceie_pkg::*;

  // ----------------------------------------
  // Stimulus, model state and counters
  // ----------------------------------------
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  ceie_addr_t addr = 12'h000;
  ceie_word_t wdata = 32'h0000_0000;
  ceie_word_t rdata;
  logic wr = 1'b0;
  logic rd = 1'b0;
  ceie_evt_t evt = 4'h0;
  logic irq;
  ceie_evt_t fl = 4'h0;
  ceie_evt_t en = 4'h0;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 29;
  logic [31:0] r;
  // Last two entries are unmapped, so reads there must come back as zero
  ceie_addr_t tbl [9] = '{`CEIE_OFF_FAST_STARTED, `CEIE_OFF_SLOW_STARTED, `CEIE_OFF_CAL_DONE,
    `CEIE_OFF_CAL_TIMEOUT, `CEIE_OFF_IRQ_EN_SET, `CEIE_OFF_IRQ_STATUS, `CEIE_OFF_IRQ_CLEAR,
    12'h008, 12'hFFC};

  ceie_clock_event_irq dut_u (
    .clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .fast_osc_started_in(evt[0]), .slow_clock_started_in(evt[1]),
    .calibration_done_in(evt[2]), .cal_timer_expired_in(evt[3]), .irq_out(irq)
  );

  // Free-running 100 MHz clock
  always #5 clk_in = ~clk_in;

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  // Read value from the bench's own copy of flags and enables
  function automatic ceie_word_t exp_rd(input ceie_addr_t a);
    case (a)
      `CEIE_OFF_FAST_STARTED: return {31'h0, fl[0]};
      `CEIE_OFF_SLOW_STARTED: return {31'h0, fl[1]};
      `CEIE_OFF_CAL_DONE: return {31'h0, fl[2]};
      `CEIE_OFF_CAL_TIMEOUT: return {31'h0, fl[3]};
      `CEIE_OFF_IRQ_EN_SET: return {28'h0, en};
      `CEIE_OFF_IRQ_STATUS: return {28'h0, fl};
      default: return 32'h0000_0000;
    endcase
  endfunction

  // Events applied last, since an event beats a clear in the same cycle
  function automatic void wr_model(input ceie_addr_t a, input ceie_word_t d, input ceie_evt_t e);
    case (a)
      `CEIE_OFF_FAST_STARTED: fl[0] = d[0];
      `CEIE_OFF_SLOW_STARTED: fl[1] = d[0];
      `CEIE_OFF_CAL_DONE: fl[2] = d[0];
      `CEIE_OFF_CAL_TIMEOUT: fl[3] = d[0];
      `CEIE_OFF_IRQ_EN_SET: en = en | d[3:0];
      `CEIE_OFF_IRQ_CLEAR: fl = fl & ~d[3:0];
      default: ;
    endcase
    fl = fl | e;
  endfunction

  // ----------------------------------------
  // Bus and event drivers
  // ----------------------------------------
  // One-cycle write with event pulses beside it; interrupt checked once it lands
  task automatic wr_op(input ceie_addr_t a, input ceie_word_t d, input ceie_evt_t e);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    evt <= e;
    @(posedge clk_in);
    wr <= 1'b0;
    evt <= 4'h0;
    wr_model(a, d, e);
    #1;
    `CHK(irq, |(fl & en))
  endtask

  // Read data stand one cycle only, so the cycle after must show zero
  task automatic rd_chk(input ceie_addr_t a);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    `CHK(rdata, exp_rd(a))
    @(posedge clk_in);
    #1;
    `CHK(rdata, 32'h0000_0000)
  endtask

  // Reset also wipes the model, enables included
  task automatic do_reset(input int n);
    nrst_in <= 1'b0;
    fl = 4'h0;
    en = 4'h0;
    repeat (n) @(posedge clk_in);
    nrst_in <= 1'b1;
  endtask

  task automatic stop_test();
    $display("Counts: checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Cycle ceiling cuts a hang short
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 10000) begin
      miscompares++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_reset(10);
    for (int i = 0; i < 9; i++) begin
      rd_chk(tbl[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr_op(12'hFFC, 32'hFFFF_FFFF, 4'h1 << i);
      rd_chk(tbl[i]);
      rd_chk(`CEIE_OFF_IRQ_STATUS);
      wr_op(tbl[i], 32'hFFFF_FFFE, 4'h0);
      rd_chk(tbl[i]);
      wr_op(`CEIE_OFF_IRQ_EN_SET, 32'h0000_0000, 4'h0);
      wr_op(`CEIE_OFF_IRQ_EN_SET, 32'h1 << i, 4'h1 << i);
      rd_chk(`CEIE_OFF_IRQ_EN_SET);
      wr_op(`CEIE_OFF_IRQ_CLEAR, 32'h1 << i, 4'h1 << i);
      wr_op(`CEIE_OFF_IRQ_CLEAR, 32'h0000_000F, 4'h0);
    end
    // Mid-run reset gives the random phase fresh enables to build up
    do_reset(3);
    for (int k = 0; k < 300; k++) begin
      r = $random(seed);
      if (r[0]) begin
        rd_chk(tbl[r[15:8] % 9]);
      end else begin
        wr_op(tbl[r[15:8] % 9], $random(seed) & $random(seed), r[7:4] & r[19:16]);
      end
    end
    stop_test();
  end
endmodule
`default_nettype wire
